/* File: testbench/sfe_link_sva.sv */
// Checker for the erase command link wires.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ps
module sfe_link_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Link
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi
);
  logic        sck_ff;
  logic [5:0]  bit_cnt_ff;
  logic [31:0] shift_ff;
  // ************
  // Frame capture
  // ************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sck_ff <= 1'b0;
      bit_cnt_ff <= 6'h00;
      shift_ff <= 32'h0;
    end else begin
      sck_ff <= sck;
      if (cs_n) begin
        bit_cnt_ff <= 6'h00;
      end else if (sck && !sck_ff) begin
        bit_cnt_ff <= bit_cnt_ff + 6'h01;
        shift_ff <= {shift_ff[30:0], mosi};
      end
    end
  end
  // ************
  // Assertions
  // ************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("sck high outside a frame");
  sck_high_a: assert property ($rose(sck) |-> sck[*4] ##1 !sck)
    else $error("sck high phase not four cycles");
  mosi_hold_a: assert property ((sck && $past(sck)) |-> $stable(mosi))
    else $error("mosi moved while sck high");
  frame_len_a: assert property ($rose(cs_n) |-> bit_cnt_ff == 6'h20)
    else $error("frame not 32 bits");
  op_code_a: assert property ($rose(cs_n) |-> shift_ff[31:24] inside {8'h81, 8'h50, 8'h7C})
    else $error("unknown erase opcode");
  dummy_zero_a: assert property ($rose(cs_n) |-> shift_ff[23:22] == 2'h0 && shift_ff[8:0] == 9'h000)
    else $error("dummy bits not zero");
  cs_gap_a: assert property ($rose(cs_n) |-> cs_n[*2])
    else $error("chip select gap too short");
  cs_fall_a: assert property ($fell(cs_n) |-> !sck ##[1:8] sck)
    else $error("no sck after frame start");
  cover property ($rose(cs_n) && shift_ff[31:24] == 8'h81);
  cover property ($rose(cs_n) && shift_ff[31:24] == 8'h50);
  cover property ($rose(cs_n) && shift_ff[31:24] == 8'h7C);
endmodule

/* File: testbench/test_serial_flash_erase_commands.sv */
// Self-checking bench for the erase host and flash device pair.
// Assumes the design files, the header and the checker compile first.
`timescale 1ns/1ps
`include "sfe_regs.svh"
module test_serial_flash_erase_commands import sfe_pkg::*;;
  typedef struct packed {
    sfe_kind_type kind;
    logic [11:0]  first;
    logic [12:0]  count;
    logic [4:0]   sector;
    logic [15:0]  cyc;
  } sfe_exp_type;
  logic clk, resetn, req, bin, verify_fail, ready, done, busy, fail_flag, start;
  sfe_kind_type kind, e_kind;
  logic [11:0]  page, e_first, p;
  logic [12:0]  e_count;
  logic [4:0]   e_sector;
  logic [3:0]   s;
  sfe_exp_type  exp_q[$];
  sfe_exp_type  cur;
  int           fail_count, total_checks, busy_cnt;
  int           sent_cnt, done_cnt;
  sfe_link_if link();
  sfe_erase_host u_sfe_erase_host (.clk(clk), .resetn(resetn), .req(req), .kind(kind),
    .binary_page_mode(bin), .page(page), .ready_ff(ready), .done_ff(done), .link(link));
  sfe_flash_dev u_sfe_flash_dev (.clk(clk), .resetn(resetn), .link(link),
    .binary_page_mode(bin), .verify_fail(verify_fail), .busy_ff(busy),
    .erase_program_fail_flag_ff(fail_flag), .erase_start_ff(start), .erase_kind_ff(e_kind),
    .erase_first_page_ff(e_first), .erase_page_count_ff(e_count), .erase_sector_ff(e_sector));
  sfe_link_sva u_sfe_link_sva (.clk(clk), .resetn(resetn), .cs_n(link.cs_n),
    .sck(link.sck), .mosi(link.mosi));
  task check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("BAD t=%0t seen=%0h want=%0h", $time, seen, want);
    end
  endtask
  task final_report;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ************
  // One erase command, waits for busy to clear
  // ************
  task send(input sfe_kind_type k, input logic vf, input sfe_exp_type e);
    int n;
    exp_q.push_back(e);
    sent_cnt++;
    kind = k;
    page = p;
    verify_fail = vf;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    n = 0;
    while (busy !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    check(busy, 1'b1);
    while (busy !== 1'b0 && n < 12000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 12000) fail_count++;
    check(fail_flag, {31'h0, vf});
    check(done_cnt, sent_cnt);
    check(ready, 1'b1);
    verify_fail = 1'b0;
    $display("test done kind=%0d page=%0h", k, p);
  endtask
  // ************
  // Result monitor
  // ************
  always @(negedge clk) begin
    if (done === 1'b1) done_cnt++;
    if (start === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        cur = exp_q.pop_front();
        check(e_kind, cur.kind);
        check(e_first, cur.first);
        check(e_count, cur.count);
        if (cur.kind == SFE_KIND_SECTOR) check(e_sector, cur.sector);
      end
      busy_cnt = 0;
    end
    if (busy === 1'b1) busy_cnt++;
    else if (busy_cnt != 0) begin
      check(busy_cnt, cur.cyc);
      busy_cnt = 0;
    end
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (80000) @(posedge clk);
    fail_count++;
    final_report;
  end
  initial begin
    resetn = 1'b0;
    req = 1'b0;
    bin = 1'b0;
    verify_fail = 1'b0;
    kind = SFE_KIND_PAGE;
    page = 12'h000;
    p = 12'h000;
    void'($urandom(32'h3275));
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    for (int m = 0; m < 2; m++) begin
      bin = m[0];
      p = 12'($urandom);
      send(SFE_KIND_PAGE, m[0], '{SFE_KIND_PAGE, p, 13'h0001, 5'h00,
        16'(`SFE_PAGE_CYC)});
      p = 12'($urandom);
      send(SFE_KIND_BLOCK, 1'b0, '{SFE_KIND_BLOCK, {p[11:3], 3'h0}, 13'h0008, 5'h00,
        16'(`SFE_BLOCK_CYC)});
    end
    p = {9'h000, 3'($urandom)};
    send(SFE_KIND_SECTOR, 1'b0, '{SFE_KIND_SECTOR, 12'h000, 13'h0008, 5'h00,
      16'(`SFE_SECTOR_CYC)});
    bin = 1'b0;
    p = {9'h001, 3'($urandom)};
    send(SFE_KIND_SECTOR, 1'b0, '{SFE_KIND_SECTOR, 12'h008, 13'h00F8, 5'h10,
      16'(`SFE_SECTOR_CYC)});
    s = 4'(1 + $urandom % 15);
    bin = 1'($urandom % 2);
    p = {s, 8'($urandom)};
    send(SFE_KIND_SECTOR, 1'b0, '{SFE_KIND_SECTOR, {s, 8'h00}, 13'h0100, {1'b0, s},
      16'(`SFE_SECTOR_CYC)});
    kind = SFE_KIND_PAGE;
    page = 12'($urandom);
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    repeat (100) @(negedge clk);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    check(link.cs_n, 1'b1);
    check(e_kind, SFE_KIND_NONE);
    resetn = 1'b1;
    repeat (600) @(negedge clk);
    check(busy, 1'b0);
    check(ready, 1'b1);
    $display("test done kind=cut frame with reset");
    repeat (4) @(negedge clk);
    check(exp_q.size(), 32'h0);
    final_report;
  end
endmodule

/* File: verilog/sfe_erase_host.sv */
// Host end: sends one erase opcode and three address bytes over SPI mode 0.
// Assumes the caller gives a page number; frame() places it for the chosen page-size mode.
`timescale 1ns/1ps
module sfe_erase_host
  import sfe_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Request
  input  wire logic        req,
  input  wire sfe_kind_type kind,
  input  wire logic        binary_page_mode,
  input  wire logic [11:0] page,
  // Answer
  output logic             ready_ff,
  output logic             done_ff,
  // Link
  sfe_link_if.host         link
);

  // ************************************************************
  // Command framing
  // ************************************************************
  function automatic logic [31:0] frame(input sfe_kind_type k, input logic bin,
                                        input logic [11:0] p);
    logic [7:0]  op;
    logic [23:0] a;
    op = (k == SFE_KIND_BLOCK)  ? `SFE_OP_BLOCK :
         (k == SFE_KIND_SECTOR) ? `SFE_OP_SECTOR : `SFE_OP_PAGE;
    a  = bin ? {3'h0, p, 9'h000} : {2'h0, p, 10'h000};
    frame = {op, a};
  endfunction

  typedef enum logic [1:0] {
    SFE_HS_IDLE = 2'b00,
    SFE_HS_LOW  = 2'b01,
    SFE_HS_HIGH = 2'b10,
    SFE_HS_END  = 2'b11
  } sfe_hstate_type;

  sfe_hstate_type         state_ff, nxt_state;
  logic [31:0]            shift_ff, nxt_shift;
  logic [`SFE_BITS_W-1:0] nbits_ff, nxt_nbits;
  logic [3:0]             div_ff, nxt_div;
  logic                   cs_n_ff, nxt_cs_n, sck_ff, nxt_sck, mosi_ff, nxt_mosi;
  logic                   nxt_ready, nxt_done, tick;

  always_comb begin
    tick      = (div_ff == `SFE_SCK_DIV);
    nxt_div   = tick ? 4'h0 : div_ff + 1'b1;
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_nbits = nbits_ff;
    nxt_cs_n  = cs_n_ff;
    nxt_sck   = sck_ff;
    nxt_mosi  = mosi_ff;
    nxt_ready = ready_ff;
    nxt_done  = 1'b0;
    case (state_ff)
      SFE_HS_IDLE: begin
        if (req && ready_ff) begin
          nxt_shift = frame(kind, binary_page_mode, page);
          nxt_nbits = '0;
          nxt_cs_n  = 1'b0;
          nxt_ready = 1'b0;
          nxt_div   = 4'h0;
          nxt_state = SFE_HS_LOW;
        end
      end
      SFE_HS_LOW: begin
        if (tick) begin
          nxt_mosi  = shift_ff[31];
          nxt_shift = {shift_ff[30:0], 1'b0};
          nxt_state = SFE_HS_HIGH;
        end
      end
      SFE_HS_HIGH: begin
        if (tick) begin
          if (!sck_ff) begin
            nxt_sck   = 1'b1;
            nxt_nbits = nbits_ff + 1'b1;
          end else begin
            nxt_sck   = 1'b0;
            nxt_state = (nbits_ff == `SFE_BITS_TOTAL) ? SFE_HS_END : SFE_HS_LOW;
          end
        end
      end
      SFE_HS_END: begin
        if (tick) begin
          nxt_cs_n  = 1'b1;
          nxt_ready = 1'b1;
          nxt_done  = 1'b1;
          nxt_state = SFE_HS_IDLE;
        end
      end
      default: nxt_state = SFE_HS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= SFE_HS_IDLE;
      shift_ff <= '0;
      nbits_ff <= '0;
      div_ff   <= '0;
      cs_n_ff  <= 1'b1;
      sck_ff   <= 1'b0;
      mosi_ff  <= 1'b0;
      ready_ff <= 1'b1;
      done_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      nbits_ff <= nxt_nbits;
      div_ff   <= nxt_div;
      cs_n_ff  <= nxt_cs_n;
      sck_ff   <= nxt_sck;
      mosi_ff  <= nxt_mosi;
      ready_ff <= nxt_ready;
      done_ff  <= nxt_done;
    end
  end

  assign link.cs_n = cs_n_ff;
  assign link.sck  = sck_ff;
  assign link.mosi = mosi_ff;

endmodule

/* File: verilog/sfe_flash_dev.sv */
// Flash device end: decodes erase commands, times the erase, reports status.
// Assumes SPI mode 0 pins synchronous to clk.
`timescale 1ns/1ps
module sfe_flash_dev
  import sfe_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Link
  sfe_link_if.dev          link,
  // Configuration and array model feedback
  input  wire logic        binary_page_mode,
  input  wire logic        verify_fail,
  // Status and erase target
  output logic             busy_ff,
  output logic             erase_program_fail_flag_ff,
  output logic             erase_start_ff,
  output sfe_kind_type     erase_kind_ff,
  output logic [11:0]      erase_first_page_ff,
  output logic [12:0]      erase_page_count_ff,
  output logic [4:0]       erase_sector_ff
);

  // ************************************************************
  // Address decode
  // ************************************************************
  function automatic logic [11:0] page_of(input logic [23:0] a, input logic bin);
    page_of = bin ? a[`SFE_BIN_PAGE_MSB:`SFE_BIN_PAGE_LSB]
                  : a[`SFE_STD_PAGE_MSB:`SFE_STD_PAGE_LSB];
  endfunction

  function automatic logic [4:0] sector_of(input logic [11:0] p);
    if (p[11:8] != 4'h0) begin
      sector_of = {1'b0, p[11:8]};
    end else if (p[3]) begin
      sector_of = `SFE_SECT_0B;
    end else begin
      sector_of = `SFE_SECT_0A;
    end
  endfunction

  // ************************************************************
  // Sector extent
  // ************************************************************
  // First page and page count packed together
  function automatic logic [24:0] sector_span(input logic [4:0] s);
    if (s == `SFE_SECT_0A) begin
      sector_span = {12'h000, 13'h0008};
    end else if (s == `SFE_SECT_0B) begin
      sector_span = {12'h008, 13'h00F8};
    end else begin
      sector_span = {s[3:0], 8'h00, 13'h0100};
    end
  endfunction

  // ************************************************************
  // Shift and sequence
  // ************************************************************
  typedef enum logic [1:0] {
    SFE_ST_IDLE  = 2'b00,
    SFE_ST_SHIFT = 2'b01,
    SFE_ST_ERASE = 2'b10
  } sfe_dstate_type;

  sfe_dstate_type       state_ff, nxt_state;
  logic [31:0]          shift_ff, nxt_shift;
  logic [`SFE_BITS_W-1:0] nbits_ff, nxt_nbits;
  logic                 sck_d_ff, nxt_sck_d;
  logic [19:0]          timer_ff, nxt_timer;
  logic                 nxt_busy, nxt_fail, nxt_start;
  sfe_kind_type         nxt_kind;
  logic [11:0]          nxt_first, page;
  logic [12:0]          nxt_count;
  logic [4:0]           nxt_sector, sect;
  logic                 sck_rise;
  logic                 timer_last;

  always_comb begin
    sck_rise   = link.sck & ~sck_d_ff;
    page       = page_of(shift_ff[23:0], binary_page_mode);
    sect       = sector_of(page);
    timer_last = (timer_ff <= 20'h00001);
    nxt_state  = state_ff;
    nxt_shift  = shift_ff;
    nxt_nbits  = nbits_ff;
    nxt_sck_d  = link.sck;
    nxt_timer  = timer_ff;
    nxt_busy   = busy_ff;
    nxt_fail   = erase_program_fail_flag_ff;
    nxt_start  = 1'b0;
    nxt_kind   = erase_kind_ff;
    nxt_first  = erase_first_page_ff;
    nxt_count  = erase_page_count_ff;
    nxt_sector = erase_sector_ff;
    case (state_ff)
      SFE_ST_IDLE: begin
        if (!link.cs_n) begin
          nxt_state = SFE_ST_SHIFT;
          nxt_nbits = '0;
        end
      end
      SFE_ST_SHIFT: begin
        if (link.cs_n) begin
          nxt_state = SFE_ST_IDLE;
          if (nbits_ff == `SFE_BITS_TOTAL) begin
            nxt_start = 1'b1;
            nxt_fail  = 1'b0;
            nxt_state = SFE_ST_ERASE;
            nxt_busy  = 1'b1;
            case (shift_ff[31:24])
              `SFE_OP_PAGE: begin
                nxt_kind  = SFE_KIND_PAGE;
                nxt_first = page;
                nxt_count = 13'h0001;
                nxt_timer = 20'(`SFE_PAGE_CYC);
              end
              `SFE_OP_BLOCK: begin
                nxt_kind  = SFE_KIND_BLOCK;
                nxt_first = {page[11:3], 3'h0};
                nxt_count = 13'h0008;
                nxt_timer = 20'(`SFE_BLOCK_CYC);
              end
              `SFE_OP_SECTOR: begin
                nxt_kind   = SFE_KIND_SECTOR;
                nxt_sector = sect;
                nxt_timer  = 20'(`SFE_SECTOR_CYC);
                {nxt_first, nxt_count} = sector_span(sect);
              end
              default: begin
                nxt_start = 1'b0;
                nxt_busy  = 1'b0;
                nxt_state = SFE_ST_IDLE;
              end
            endcase
          end
        end else if (sck_rise && nbits_ff != `SFE_BITS_TOTAL) begin
          nxt_shift = {shift_ff[30:0], link.mosi};
          nxt_nbits = nbits_ff + 1'b1;
        end
      end
      SFE_ST_ERASE: begin
        if (verify_fail) begin
          nxt_fail = 1'b1;
        end
        // Frames arriving now are ignored; one still open when the erase ends is decoded if all 32 of its sck rises come after that
        if (timer_last) begin
          nxt_busy  = 1'b0;
          nxt_state = SFE_ST_IDLE;
        end else begin
          nxt_timer = timer_ff - 1'b1;
        end
      end
      default: nxt_state = SFE_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff                   <= SFE_ST_IDLE;
      shift_ff                   <= '0;
      nbits_ff                   <= '0;
      sck_d_ff                   <= 1'b0;
      timer_ff                   <= '0;
      busy_ff                    <= 1'b0;
      erase_program_fail_flag_ff <= 1'b0;
      erase_start_ff             <= 1'b0;
      erase_kind_ff              <= SFE_KIND_NONE;
      erase_first_page_ff        <= '0;
      erase_page_count_ff        <= '0;
      erase_sector_ff            <= '0;
    end else begin
      state_ff                   <= nxt_state;
      shift_ff                   <= nxt_shift;
      nbits_ff                   <= nxt_nbits;
      sck_d_ff                   <= nxt_sck_d;
      timer_ff                   <= nxt_timer;
      busy_ff                    <= nxt_busy;
      erase_program_fail_flag_ff <= nxt_fail;
      erase_start_ff             <= nxt_start;
      erase_kind_ff              <= nxt_kind;
      erase_first_page_ff        <= nxt_first;
      erase_page_count_ff        <= nxt_count;
      erase_sector_ff            <= nxt_sector;
    end
  end

endmodule

/* File: verilog/sfe_link_if.sv */
// SPI link between the erase host and the flash device.
// Assumes both ends run on the same clk.
`timescale 1ns/1ps
interface sfe_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  modport host (output cs_n, output sck, output mosi);
  modport dev  (input cs_n, input sck, input mosi);
endinterface

/* File: verilog/sfe_pkg.sv */
// Types shared by both ends of the erase command link.
// Assumes sfe_regs.svh in the include path.
`include "sfe_regs.svh"
package sfe_pkg;
  typedef enum logic [1:0] {
    SFE_KIND_PAGE   = 2'b00,
    SFE_KIND_BLOCK  = 2'b01,
    SFE_KIND_SECTOR = 2'b10,
    SFE_KIND_NONE   = 2'b11
  } sfe_kind_type;
endpackage

/* File: verilog/sfe_regs.svh */
// Constants for the serial flash erase command path.
// Assumes inclusion by the package and the bench; both end modules use its macros.
`ifndef SFE_REGS_SVH
`define SFE_REGS_SVH
`define SFE_OP_PAGE        8'h81
`define SFE_OP_BLOCK       8'h50
`define SFE_OP_SECTOR      8'h7C
`define SFE_BITS_TOTAL     6'h20
`define SFE_BITS_W         6
`define SFE_STD_PAGE_MSB   21
`define SFE_STD_PAGE_LSB   10
`define SFE_BIN_PAGE_MSB   20
`define SFE_BIN_PAGE_LSB   9
`define SFE_PAGE_ERASE_MAX_TIME_US   25
`define SFE_BLOCK_ERASE_MAX_TIME_US  50
`define SFE_SECTOR_ERASE_MAX_TIME_US 200
`define SFE_CLK_MHZ        50
`define SFE_PAGE_CYC   (`SFE_PAGE_ERASE_MAX_TIME_US * `SFE_CLK_MHZ)
`define SFE_BLOCK_CYC  (`SFE_BLOCK_ERASE_MAX_TIME_US * `SFE_CLK_MHZ)
`define SFE_SECTOR_CYC (`SFE_SECTOR_ERASE_MAX_TIME_US * `SFE_CLK_MHZ)
`define SFE_SCK_DIV        4'h3
`define SFE_SECT_0A        5'h00
`define SFE_SECT_0B        5'h10
`endif
